// ---- hw/rops_pkg.sv ----
`default_nettype none
package rops_pkg;
   // =========================================================
   // geometry
   localparam int NUM_PINS = 13;
   localparam int SEL_W = 5;
   localparam int IN_SEL_W = 4;
   localparam int ADDR_W = 8;
   localparam int NUM_CODES = 22;
   // =========================================================
   // register offsets (byte addresses); pin n select at PIN_BASE + 4*n
   localparam logic [7:0] OFS_PIN_BASE = 8'h00;
   localparam logic [7:0] OFS_CONFIG_CONTROL = 8'h40;
   localparam logic [7:0] OFS_UNLOCK_KEY = 8'h44;
   localparam logic [7:0] OFS_IN_SEL = 8'h48;
   localparam logic [7:0] OFS_STATUS = 8'h4C;
   // =========================================================
   // fields and reset values
   localparam int LOCK_BIT = 13;
   localparam int ONE_WAY_BIT = 29;
   localparam int STAT_SET_ONCE_BIT = 1;
   localparam int STAT_UNLOCKED_BIT = 2;
   localparam logic [SEL_W-1:0] SEL_RESET = 5'h00;
   localparam logic [IN_SEL_W-1:0] IN_SEL_RESET = 4'h0;
   localparam logic ONE_WAY_RESET = 1'b1;
   // =========================================================
   // null and reserved select codes, and the highest code that names an output
   localparam logic [SEL_W-1:0] CODE_OFF = 5'h00;
   localparam logic [SEL_W-1:0] CODE_RES_A = 5'h0D;
   localparam logic [SEL_W-1:0] CODE_RES_B = 5'h13;
   localparam logic [SEL_W-1:0] CODE_LAST = 5'h15;
   // unlock key pair; values are arbitrary
   localparam logic [31:0] KEY_FIRST = 32'h0F1E_2D3C;
   localparam logic [31:0] KEY_SECOND = 32'hC3D2_E1F0;
   // =========================================================
   // peripheral outputs, packed so that bit position equals select code
   typedef struct packed {
      logic quadrature_compare_6;
      logic quadrature_compare_2;
      logic res_19;
      logic reference_clock_out_3;
      logic serial_port6_clock;
      logic serial_port5_data_out;
      logic serial_port4_data_out;
      logic serial_port3_data_out;
      logic res_13;
      logic can4_transmit;
      logic uart6_request_to_send;
      logic compare_out_16;
      logic compare_out_12;
      logic compare_out_9;
      logic comparator3_output;
      logic compare_out_8;
      logic compare_out_2;
      logic serial_port2_data_out;
      logic serial_port1_data_out;
      logic uart4_transmit;
      logic uart3_request_to_send;
      logic res_off;
   } rops_periph_t;
   typedef enum logic [1:0] {
      KEY_IDLE = 2'b00,
      KEY_HALF = 2'b01,
      KEY_OPEN = 2'b11
   } rops_key_t;
   typedef struct packed {
      logic set_once;
      logic mapping_lock;
   } rops_lock_t;
endpackage
`default_nettype wire

// ---- hw/rops_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module rops_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [rops_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire rops_pkg::rops_periph_t periph_out,
   input wire logic [31:0] cfg_word_three,
   output logic [rops_pkg::NUM_PINS-1:0] pin_out,
   output logic [rops_pkg::NUM_PINS-1:0] pin_oe,
   output logic [rops_pkg::IN_SEL_W-1:0] periph_in_sel
);
   import rops_pkg::*;

   // =========================================================
   // state
   logic [SEL_W-1:0] sel [NUM_PINS];
   logic [SEL_W-1:0] next_sel [NUM_PINS];
   logic [IN_SEL_W-1:0] next_periph_in_sel;
   rops_lock_t lock;
   rops_lock_t next_lock;
   rops_key_t key;
   rops_key_t next_key;
   logic one_way;
   logic next_one_way;
   logic opt_s1, opt_s2, opt_s3;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic [NUM_PINS-1:0] next_pin_out;
   logic [NUM_PINS-1:0] next_pin_oe;
   logic [NUM_CODES-1:0] periph_vec;
   logic access;
   logic pin_hit;
   logic [5:0] word_idx;
   logic mapped;
   logic [31:0] rd_value;

   assign periph_vec = periph_out;
   assign word_idx = paddr[7:2];
   assign pin_hit = (paddr[1:0] == 2'b00) && (word_idx < 6'(NUM_PINS));
   // the transfer commits on the edge where the master sees pready high
   assign access = psel && penable && pready;

   function automatic logic code_valid(input logic [SEL_W-1:0] c);
      return (c != CODE_OFF) && (c <= CODE_LAST) && (c != CODE_RES_A) && (c != CODE_RES_B);
   endfunction

   // =========================================================
   // one-way option: a fuse level from outside the clock domain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opt_s1 <= ONE_WAY_RESET;
         opt_s2 <= ONE_WAY_RESET;
         opt_s3 <= ONE_WAY_RESET;
      end else begin
         opt_s1 <= cfg_word_three[ONE_WAY_BIT];
         opt_s2 <= opt_s1;
         opt_s3 <= opt_s2;
      end
   end

   always_comb begin
      next_one_way = one_way;
      if (opt_s2 == opt_s3) begin
         next_one_way = opt_s3;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         one_way <= ONE_WAY_RESET;
      end else begin
         one_way <= next_one_way;
      end
   end

   // =========================================================
   // register decode and read data
   always_comb begin
      mapped = 1'b1;
      rd_value = 32'h0000_0000;
      if (pin_hit) begin
         rd_value[SEL_W-1:0] = sel[word_idx[3:0]];
      end else begin
         case (paddr)
            OFS_CONFIG_CONTROL: rd_value[LOCK_BIT] = lock.mapping_lock;
            OFS_UNLOCK_KEY: rd_value = 32'h0000_0000;
            OFS_IN_SEL: rd_value[IN_SEL_W-1:0] = periph_in_sel;
            OFS_STATUS: begin
               rd_value[0] = one_way;
               rd_value[STAT_SET_ONCE_BIT] = lock.set_once;
               rd_value[STAT_UNLOCKED_BIT] = (key == KEY_OPEN);
            end
            default: mapped = 1'b0;
         endcase
      end
   end

   // =========================================================
   // apb answer: one wait state, read data and error held with pready
   always_comb begin
      next_pready = psel && penable && !pready;
      next_prdata = prdata;
      next_pslverr = 1'b0;
      if (next_pready) begin
         next_prdata = pwrite ? 32'h0000_0000 : rd_value;
         // a locked write answers without error
         next_pslverr = !mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= next_pready;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   // =========================================================
   // unlock key sequence and mapping lock
   always_comb begin
      next_key = key;
      next_lock = lock;
      if (access && pwrite && mapped) begin
         if (paddr == OFS_UNLOCK_KEY) begin
            case (key)
               KEY_IDLE: next_key = (pwdata == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
               KEY_HALF: next_key = (pwdata == KEY_SECOND) ? KEY_OPEN : KEY_IDLE;
               KEY_OPEN: next_key = KEY_OPEN;
               default: next_key = KEY_IDLE;
            endcase
         end else if (paddr == OFS_CONFIG_CONTROL) begin
            // lock bit changes only after the key pair
            if (key == KEY_OPEN) begin
               // bit 13 of the config control register
               if (pwdata[LOCK_BIT]) begin
                  next_lock.mapping_lock = 1'b1;
                  next_lock.set_once = 1'b1;
               end else if (!(one_way && lock.set_once)) begin
                  next_lock.mapping_lock = 1'b0;
               end
            end
            next_key = KEY_IDLE;
         end else begin
            next_key = KEY_IDLE;
         end
      end
   end

   // reset, or a clear after the key pair once the one-way option drops, releases a stuck lock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key <= KEY_IDLE;
         lock <= '0;
      end else begin
         key <= next_key;
         lock <= next_lock;
      end
   end

   // =========================================================
   // select registers and pin drive, one slice per pin
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
         always_comb begin
            next_sel[gi] = sel[gi];
            // locked writes leave the field as it was
            if (access && pwrite && pin_hit && (word_idx == 6'(gi)) && !lock.mapping_lock) begin
               next_sel[gi] = pwdata[SEL_W-1:0];
            end
            // codes above CODE_LAST drive nothing, like the null code
            // reserved codes behave as null output
            next_pin_oe[gi] = code_valid(sel[gi]);
            next_pin_out[gi] = code_valid(sel[gi]) ? periph_vec[sel[gi]] : 1'b0;
         end

         // fields reset to the null code
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sel[gi] <= SEL_RESET;
               pin_out[gi] <= 1'b0;
               pin_oe[gi] <= 1'b0;
            end else begin
               sel[gi] <= next_sel[gi];
               pin_out[gi] <= next_pin_out[gi];
               pin_oe[gi] <= next_pin_oe[gi];
            end
         end
      end
   endgenerate

   // input select shares the lock with the output selects
   always_comb begin
      next_periph_in_sel = periph_in_sel;
      // input select also guarded by the lock
      if (access && pwrite && (paddr == OFS_IN_SEL) && !lock.mapping_lock) begin
         next_periph_in_sel = pwdata[IN_SEL_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         periph_in_sel <= IN_SEL_RESET;
      end else begin
         periph_in_sel <= next_periph_in_sel;
      end
   end

   // =========================================================
   // checks
   chk_sel_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
      access && pwrite && paddr == OFS_PIN_BASE && !lock.mapping_lock
      |=> sel[0] == $past(pwdata[SEL_W-1:0]))
      else $error("unlocked select write did not land");

   chk_null_undriven: assert property (@(posedge pclk) disable iff (!presetn)
      sel[1] == CODE_OFF |=> !pin_oe[1] && !pin_out[1])
      else $error("null select still drives the pin");

   chk_locked_hold: assert property (@(posedge pclk) disable iff (!presetn)
      lock.mapping_lock && access && pwrite && pin_hit |=> $stable(sel[1]) && $stable(sel[0]))
      else $error("locked write changed a select field");

   chk_locked_noerr: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pready && pwrite && pin_hit |=> pready && !pslverr)
      else $error("locked or mapped write answered with error");

   chk_lock_blocks_in: assert property (@(posedge pclk) disable iff (!presetn)
      lock.mapping_lock && access && pwrite && paddr == OFS_IN_SEL |=> $stable(periph_in_sel))
      else $error("input select changed while locked");

   chk_key_needed: assert property (@(posedge pclk) disable iff (!presetn)
      key != KEY_OPEN |=> lock.mapping_lock == $past(lock.mapping_lock))
      else $error("lock changed without unlock key");

   chk_one_way_stuck: assert property (@(posedge pclk) disable iff (!presetn)
      one_way && lock.set_once && lock.mapping_lock ##1 one_way |-> lock.mapping_lock)
      else $error("one-way lock was cleared");

   chk_decode_code: assert property (@(posedge pclk) disable iff (!presetn)
      sel[3] == 5'h03 |=> pin_out[3] == $past(periph_out.serial_port1_data_out) && pin_oe[3])
      else $error("code three did not route serial data out");

   chk_decode_high: assert property (@(posedge pclk) disable iff (!presetn)
      sel[8] == 5'h15 |=> pin_out[8] == $past(periph_out.quadrature_compare_6) && pin_oe[8])
      else $error("code 21 did not route quadrature compare");

   chk_reserved_null: assert property (@(posedge pclk) disable iff (!presetn)
      (sel[5] == CODE_RES_A || sel[5] > CODE_LAST) |=> !pin_oe[5] && !pin_out[5])
      else $error("reserved code drove the pin");

   chk_lock_sets: assert property (@(posedge pclk) disable iff (!presetn)
      key == KEY_OPEN && access && pwrite && paddr == OFS_CONFIG_CONTROL && pwdata[LOCK_BIT]
      |=> lock.mapping_lock)
      else $error("keyed lock write did not set the lock");

   chk_in_sel_lands: assert property (@(posedge pclk) disable iff (!presetn)
      !lock.mapping_lock && access && pwrite && paddr == OFS_IN_SEL
      |=> periph_in_sel == $past(pwdata[IN_SEL_W-1:0]))
      else $error("unlocked input select write did not land");

   chk_write_completes: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pready |=> pready)
      else $error("access phase got no ready in the next cycle");

   chk_set_once_held: assert property (@(posedge pclk) disable iff (!presetn)
      lock.set_once |=> lock.set_once)
      else $error("set-once memory cleared without reset");

   chk_option_follow: assert property (@(posedge pclk) disable iff (!presetn)
      opt_s2 == opt_s3 |=> one_way == $past(opt_s3))
      else $error("option level not taken once synchroniser agreed");

   chk_decode_mid: assert property (@(posedge pclk) disable iff (!presetn)
      sel[1] == 5'h0E |=> pin_out[1] == $past(periph_out.serial_port3_data_out) && pin_oe[1])
      else $error("code 14 did not route serial data out");
endmodule // rops_top
`default_nettype wire

// ---- tb/rops_periph_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// =========================================================
// peripheral outputs seen by the pin selector
module rops_periph_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic [21:0] pattern,
   output var rops_pkg::rops_periph_t periph_out
);
   import rops_pkg::*;
   logic flip;
   // free-running toggling stands in for live peripherals; halted so pin levels are predictable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flip <= 1'b0;
      end else begin
         flip <= run ? ~flip : 1'b0;
      end
   end
   assign periph_out = pattern ^ {22{flip}};
endmodule // rops_periph_model
`default_nettype wire

// ---- tb/rops_top_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module rops_top_tb_top;
   import rops_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, run;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, cfg_word_three, rd;
   logic [NUM_PINS-1:0] pin_out, pin_oe;
   logic [IN_SEL_W-1:0] periph_in_sel;
   logic [21:0] pattern;
   rops_periph_t periph_out;
   int n_mismatch, comparisons;
   rops_top rops_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .periph_out(periph_out), .cfg_word_three(cfg_word_three),
      .pin_out(pin_out), .pin_oe(pin_oe), .periph_in_sel(periph_in_sel));
   rops_periph_model rops_periph_model_i (.pclk(pclk), .presetn(presetn), .run(run),
      .pattern(pattern), .periph_out(periph_out));
   // =========================================================
   // clock and watchdog
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      #20000;
      n_mismatch++;
      $display("[FAIL] watchdog expected done seen hang");
      complete_run();
   end
   // =========================================================
   // bus tasks and checks
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_mismatch++;
         $display("[FAIL] pready expected 1 seen timeout");
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   // key pair followed by the config write that it permits
   task automatic set_config(input logic [31:0] v);
      apb(1'b1, OFS_UNLOCK_KEY, KEY_FIRST);
      apb(1'b1, OFS_UNLOCK_KEY, KEY_SECOND);
      apb(1'b1, OFS_CONFIG_CONTROL, v);
   endtask
   task automatic do_reset(input logic one_way);
      @(posedge pclk);
      presetn <= 1'b0;
      cfg_word_three <= {2'b00, one_way, 29'h0};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      // option crosses a synchroniser before it is trusted
      repeat (6) @(posedge pclk);
   endtask
   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // =========================================================
   // tests
   initial begin
      logic v;
      int p;
      presetn = 1'b0;
      {psel, penable, pwrite, run} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      cfg_word_three = 32'h2000_0000;
      pattern = 22'h15_5555;
      n_mismatch = 0;
      comparisons = 0;
      run = 1'b1;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      for (int i = 0; i < NUM_PINS; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0000_0000);
         chk("sel_reset", 32'h0000_0000, rd);
      end
      chk("oe_reset", 32'h0000_0000, 32'(pin_oe));
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      chk("one_way_default", 32'h0000_0001, 32'(rd[0]));
      apb(1'b0, 8'h50, 32'h0000_0000);
      chk("unmapped_err", 32'h0000_0001, 32'(er));
      run <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         for (int c = 0; c < 32; c++) begin
            p = c % NUM_PINS;
            v = (c != 0 && c != 13 && c != 19 && c <= 21);
            apb(1'b1, 8'(4 * p), 32'(c));
            apb(1'b0, 8'(4 * p), 32'h0000_0000);
            chk("sel_field", 32'(c), rd);
            repeat (2) @(posedge pclk);
            #1;
            chk("pin_oe", 32'(v), 32'(pin_oe[p]));
            chk("pin_out", v ? 32'(pattern[c]) : 32'h0, 32'(pin_out[p]));
         end
         @(posedge pclk);
         pattern <= ~pattern;
      end
      apb(1'b1, 8'h04, 32'h0000_0003);
      set_config(32'h0000_2000);
      apb(1'b0, OFS_CONFIG_CONTROL, 32'h0000_0000);
      chk("lock_set", 32'h0000_2000, rd);
      apb(1'b1, 8'h04, 32'h0000_0005);
      chk("locked_err", 32'h0000_0000, 32'(er));
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk("locked_sel", 32'h0000_0003, rd);
      apb(1'b1, OFS_IN_SEL, 32'h0000_0007);
      apb(1'b0, OFS_IN_SEL, 32'h0000_0000);
      chk("locked_in_sel", 32'h0000_0000, rd);
      set_config(32'h0000_0000);
      apb(1'b0, OFS_CONFIG_CONTROL, 32'h0000_0000);
      chk("lock_sticks", 32'h0000_2000, rd);
      do_reset(1'b0);
      apb(1'b0, OFS_CONFIG_CONTROL, 32'h0000_0000);
      chk("lock_after_reset", 32'h0000_0000, rd);
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk("sel_after_reset", 32'h0000_0000, rd);
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      chk("one_way_off", 32'h0000_0000, 32'(rd[0]));
      set_config(32'h0000_2000);
      set_config(32'h0000_0000);
      apb(1'b0, OFS_CONFIG_CONTROL, 32'h0000_0000);
      chk("lock_cleared", 32'h0000_0000, rd);
      apb(1'b1, 8'h04, 32'h0000_0009);
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk("sel_unlocked", 32'h0000_0009, rd);
      apb(1'b1, OFS_IN_SEL, 32'h0000_0007);
      apb(1'b0, OFS_IN_SEL, 32'h0000_0000);
      chk("in_sel_unlocked", 32'h0000_0007, rd);
      chk("in_sel_port", 32'h0000_0007, 32'(periph_in_sel));
      complete_run();
   end
endmodule // rops_top_tb_top
`default_nettype wire
